// ==== hdl/adc_seq_pkg.sv ====
`default_nettype none
package adc_seq_pkg;

    // Register indices on the plain port (byte-wide data in the low bits).
    localparam logic [3:0] CTRL_IDX = 4'h0;
    localparam logic [3:0] CFG_IDX = 4'h1;
    localparam logic [3:0] RES_HI_IDX = 4'h2;
    localparam logic [3:0] RES_LO_IDX = 4'h3;
    localparam logic [3:0] FLAG_IDX = 4'h4;

    // Control register fields.
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_GO_BIT = 1;

    // Acquisition/clock configuration register fields.
    localparam int ACQ_LSB = 3;
    localparam int CCS_LSB = 0;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [2:0] ACQ_MANUAL = 3'h0;

    // Conversion timing in bit periods.
    localparam logic [4:0] CONV_BITS = 5'h0B;
    localparam logic [4:0] RECOVER_BITS = 5'h02;
    localparam logic [4:0] MANUAL_DELAY_BITS = 5'h01;

    // Instruction cycle is four oscillator periods.
    localparam logic [1:0] INSTR_DIV_MAX = 2'h3;

    // Internal RC bit period: 1.2 us typical.
    localparam int RC_PERIOD_NS = 1200;
    localparam int CLK_PERIOD_NS = 20;
    localparam int RC_DIV_CYCLES = (RC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_SAMPLE = 3'h0,
        ST_DELAY = 3'h1,
        ST_ACQ = 3'h2,
        ST_CONV = 3'h3,
        ST_RECOVER = 3'h4
    } seq_state_type;

    typedef struct packed {
        logic sample_en;
        logic convert_en;
        logic bit_strobe;
    } analog_ctl_type;

endpackage
`default_nettype wire

// ==== hdl/tad_divider.sv ====
`timescale 1ns/10ps
`default_nettype none
module tad_divider #(
    parameter int RC_DIV = 60
) (
    input wire logic clk, // System clock.
    input wire logic rstn, // Asynchronous reset, active low.
    input wire logic run, // Divider counts only while high.
    input wire logic [2:0] sel, // Conversion clock select.
    output logic tick // One-cycle pulse per bit period.
);
    logic [6:0] cnt_r;
    logic [6:0] cnt_nxt;
    logic [6:0] limit;

    // Select codes 000,100,001,101,010,110 give 2..64 periods; x11 is the RC source.
    function automatic logic [6:0] div_limit(input logic [2:0] s);
        logic [6:0] v;
        v = 7'h01;
        unique case (s)
            3'h0: v = 7'h01;
            3'h4: v = 7'h03;
            3'h1: v = 7'h07;
            3'h5: v = 7'h0F;
            3'h2: v = 7'h1F;
            3'h6: v = 7'h3F;
            3'h3, 3'h7: v = 7'(RC_DIV - 1);
        endcase
        return v;
    endfunction

    assign limit = div_limit(sel);
    assign tick = run && (cnt_r == limit);
    assign cnt_nxt = (!run || tick) ? 7'h00 : cnt_r + 7'h01;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 7'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    tick_spacing_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(run) && sel == 3'h0 |-> !tick ##1 tick)
        else $error("bit period of two clocks not produced");
endmodule
`default_nettype wire

// ==== hdl/adc_acquisition_sequencer.sv ====
// Notes on behaviour
// - Acquisition select, bits 5:3 of configuration, picks 2 to 20 bit periods.
// - Nonzero acquisition: go keeps sampling for that time, then converts.
// - Acquisition code 000: go stops sampling and converts without acquisition.
// - Acquisition select resets to 000, manual mode.
// - On completion clear go, set done flag, resume sampling.
// - No status shows acquisition end or conversion start; only go.
// - Conversion lasts exactly 11 bit periods.
// - Clock select decodes 2,4,8,16,32,64 oscillator periods or RC source.
// - Manual mode delays conversion start by one instruction cycle.
// - Completion loads 10-bit result into high and low registers.
// - Clearing go aborts; result registers keep previous value.
// - After completion or abort wait 2 bit periods before sampling.
// - Trigger ignored while converter is off.
`timescale 1ns/10ps
`default_nettype none
module adc_acquisition_sequencer #(
    parameter int RC_DIV = adc_seq_pkg::RC_DIV_CYCLES
) (
    input wire logic clk, // 50 MHz system clock.
    input wire logic rstn, // Asynchronous reset, active low.
    input wire logic [3:0] addr, // Register index.
    input wire logic [7:0] wdata, // Write data.
    input wire logic wr, // Write strobe.
    input wire logic rd, // Read strobe.
    output logic [7:0] rdata, // Read data, valid the cycle after rd.
    input wire logic trigger, // Compare unit special event, same clock.
    input wire logic [9:0] sar_result, // Result from successive approximation logic.
    output var adc_seq_pkg::analog_ctl_type analog_ctl, // Sample switch and conversion controls.
    output logic conv_done_irq_flag // Sticky done flag.
);
    adc_seq_pkg::seq_state_type state_r, state_nxt;
    logic [7:0] cfg_r;
    logic on_r;
    logic go_r;
    logic go_nxt;
    logic flag_r;
    logic [9:0] result_r;
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic [1:0] icyc_r;
    logic [7:0] rdata_r;
    logic tick;
    logic [2:0] acq_sel;
    logic [2:0] clk_sel;
    logic manual;
    logic wr_ctrl;
    logic wr_flag;
    logic wr_hi;
    logic wr_lo;
    logic go_set;
    logic go_clr_sw;
    logic cnt_last;
    logic done;
    logic busy;
    logic instr_tick;
    logic [7:0] rsel;
    logic abort;
    logic div_run;
    logic start;

    // Acquisition codes 1..7 give 2,4,6,8,12,16,20 bit periods.
    function automatic logic [4:0] acq_len(input logic [2:0] s);
        logic [4:0] v;
        v = 5'h02;
        unique case (s)
            3'h0: v = 5'h00;
            3'h1: v = 5'h02;
            3'h2: v = 5'h04;
            3'h3: v = 5'h06;
            3'h4: v = 5'h08;
            3'h5: v = 5'h0C;
            3'h6: v = 5'h10;
            3'h7: v = 5'h14;
        endcase
        return v;
    endfunction

    assign acq_sel = cfg_r[adc_seq_pkg::ACQ_LSB +: 3];
    assign clk_sel = cfg_r[adc_seq_pkg::CCS_LSB +: 3];
    assign manual = (acq_sel == adc_seq_pkg::ACQ_MANUAL);
    assign wr_ctrl = wr && (addr == adc_seq_pkg::CTRL_IDX);
    assign wr_flag = wr && (addr == adc_seq_pkg::FLAG_IDX);
    assign wr_hi = wr && (addr == adc_seq_pkg::RES_HI_IDX);
    assign wr_lo = wr && (addr == adc_seq_pkg::RES_LO_IDX);
    // A go request while off is dropped, as is the trigger.
    assign go_set = on_r && ((wr_ctrl && wdata[adc_seq_pkg::CTRL_GO_BIT]) || trigger);
    assign go_clr_sw = wr_ctrl && !wdata[adc_seq_pkg::CTRL_GO_BIT];
    assign busy = (state_r == adc_seq_pkg::ST_DELAY) || (state_r == adc_seq_pkg::ST_ACQ)
        || (state_r == adc_seq_pkg::ST_CONV);
    assign cnt_last = tick && (cnt_r == 5'h01);
    assign done = (state_r == adc_seq_pkg::ST_CONV) && cnt_last && go_r;
    assign instr_tick = (icyc_r == adc_seq_pkg::INSTR_DIV_MAX);
    assign abort = busy && (!go_r || !on_r);
    // The divider restarts as a conversion or recovery begins, so no bit period comes out short.
    assign div_run = (state_r != adc_seq_pkg::ST_SAMPLE) && !abort
        && !((state_r == adc_seq_pkg::ST_DELAY) && instr_tick);
    // A go set during recovery is kept and starts the next cycle once sampling resumes.
    assign start = go_set || (go_r && on_r);

    tad_divider #(
        .RC_DIV(RC_DIV)
    ) u_div (
        .clk(clk),
        .rstn(rstn),
        .run(div_run),
        .sel(clk_sel),
        .tick(tick)
    );

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        unique case (state_r)
            adc_seq_pkg::ST_SAMPLE: begin
                if (start && manual) begin
                    state_nxt = adc_seq_pkg::ST_DELAY;
                end else if (start) begin
                    state_nxt = adc_seq_pkg::ST_ACQ;
                    cnt_nxt = acq_len(acq_sel);
                end
            end
            adc_seq_pkg::ST_DELAY: begin
                if (instr_tick) begin
                    state_nxt = adc_seq_pkg::ST_CONV;
                    cnt_nxt = adc_seq_pkg::CONV_BITS;
                end
            end
            adc_seq_pkg::ST_ACQ: begin
                if (tick) begin
                    cnt_nxt = cnt_r - 5'h01;
                end
                if (cnt_last) begin
                    state_nxt = adc_seq_pkg::ST_CONV;
                    cnt_nxt = adc_seq_pkg::CONV_BITS;
                end
            end
            adc_seq_pkg::ST_CONV: begin
                if (tick) begin
                    cnt_nxt = cnt_r - 5'h01;
                end
                if (cnt_last) begin
                    state_nxt = adc_seq_pkg::ST_RECOVER;
                    cnt_nxt = adc_seq_pkg::RECOVER_BITS;
                end
            end
            adc_seq_pkg::ST_RECOVER: begin
                if (tick) begin
                    cnt_nxt = cnt_r - 5'h01;
                end
                if (cnt_last) begin
                    state_nxt = adc_seq_pkg::ST_SAMPLE;
                end
            end
            default: begin
                state_nxt = adc_seq_pkg::ST_SAMPLE;
            end
        endcase
        // Abort: go cleared by software or converter switched off while busy.
        if (abort) begin
            state_nxt = adc_seq_pkg::ST_RECOVER;
            cnt_nxt = adc_seq_pkg::RECOVER_BITS;
        end
    end

    // Go drops on completion; a fresh set wins over completion in the same cycle.
    assign go_nxt = go_set ? 1'b1 : (go_clr_sw || done || !on_r) ? 1'b0 : go_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= adc_seq_pkg::ST_SAMPLE;
            cnt_r <= 5'h00;
            icyc_r <= 2'h0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            icyc_r <= (state_r == adc_seq_pkg::ST_DELAY) ? icyc_r + 2'h1 : 2'h0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_r <= adc_seq_pkg::CFG_RESET;
            on_r <= 1'b0;
            go_r <= 1'b0;
            flag_r <= 1'b0;
        end else begin
            if (wr && addr == adc_seq_pkg::CFG_IDX) begin
                cfg_r <= wdata & 8'h3F;
            end
            if (wr_ctrl) begin
                on_r <= wdata[adc_seq_pkg::CTRL_ON_BIT];
            end
            go_r <= go_nxt;
            // Hardware set wins over a software clear in the same cycle.
            flag_r <= done ? 1'b1 : (wr_flag && !wdata[0]) ? 1'b0 : flag_r;
        end
    end

    // Result has no reset value; software may also write it.
    always_ff @(posedge clk) begin
        if (done) begin
            result_r <= sar_result;
        end else begin
            if (wr_hi) begin
                result_r[9:8] <= wdata[1:0];
            end
            if (wr_lo) begin
                result_r[7:0] <= wdata;
            end
        end
    end

    // Control readback shows only go and on; the phase stays hidden.
    assign rsel = (addr == adc_seq_pkg::CTRL_IDX) ? {6'h00, go_r, on_r} :
        (addr == adc_seq_pkg::CFG_IDX) ? cfg_r :
        (addr == adc_seq_pkg::RES_HI_IDX) ? {6'h00, result_r[9:8]} :
        (addr == adc_seq_pkg::RES_LO_IDX) ? result_r[7:0] :
        (addr == adc_seq_pkg::FLAG_IDX) ? {7'h00, flag_r} : 8'h00;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rd ? rsel : 8'h00;
        end
    end

    assign rdata = rdata_r;
    assign conv_done_irq_flag = flag_r;
    assign analog_ctl = '{
        sample_en: (state_r == adc_seq_pkg::ST_SAMPLE) || (state_r == adc_seq_pkg::ST_ACQ),
        convert_en: (state_r == adc_seq_pkg::ST_CONV),
        bit_strobe: tick && (state_r == adc_seq_pkg::ST_CONV)
    };

    manual_stop_a: assert property (@(posedge clk) disable iff (!rstn)
        state_r == adc_seq_pkg::ST_SAMPLE && go_set && manual |=> !analog_ctl.sample_en)
        else $error("manual start did not stop sampling");
    manual_delay_a: assert property (@(posedge clk) disable iff (!rstn)
        state_r == adc_seq_pkg::ST_SAMPLE && go_set && manual && on_r && !go_clr_sw
        |=> (state_r == adc_seq_pkg::ST_DELAY) [*4])
        else $error("manual start not delayed one instruction");
    auto_acq_a: assert property (@(posedge clk) disable iff (!rstn)
        state_r == adc_seq_pkg::ST_SAMPLE && go_set && !manual |=> state_r == adc_seq_pkg::ST_ACQ)
        else $error("programmed acquisition not entered");
    done_flag_a: assert property (@(posedge clk) disable iff (!rstn)
        done |=> flag_r && (!go_r || $past(go_set)) && state_r == adc_seq_pkg::ST_RECOVER)
        else $error("completion effects missing");
    result_load_a: assert property (@(posedge clk) disable iff (!rstn)
        done |=> result_r == $past(sar_result))
        else $error("result not loaded");
    abort_keep_a: assert property (@(posedge clk) disable iff (!rstn)
        busy && !go_r && !wr_hi && !wr_lo |=> $stable(result_r) && state_r == adc_seq_pkg::ST_RECOVER)
        else $error("abort changed result");
    off_ignore_a: assert property (@(posedge clk) disable iff (!rstn)
        !on_r && !go_r |=> !go_r)
        else $error("go set while converter off");
    conv_len_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(analog_ctl.convert_en) |-> cnt_r == adc_seq_pkg::CONV_BITS && !tick)
        else $error("conversion length wrong");
    recover_a: assert property (@(posedge clk) disable iff (!rstn)
        state_r == adc_seq_pkg::ST_RECOVER && $past(state_r) != adc_seq_pkg::ST_RECOVER
        |-> cnt_r == adc_seq_pkg::RECOVER_BITS)
        else $error("recovery wait not two bit periods");
endmodule
`default_nettype wire

// ==== testbench/sar_front_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module sar_front_model (
    input wire adc_seq_pkg::analog_ctl_type analog_ctl, // Controls from the sequencer.
    input wire logic clk, // System clock.
    input wire logic rstn, // Asynchronous reset, active low.
    input wire logic [9:0] code, // Level presented at the analog input.
    output logic [9:0] sar_result, // Approximation result.
    output logic [4:0] strobes // Bit strobes seen in the latest conversion.
);
    logic [9:0] held_r;
    logic conv_d_r;
    // Outside a conversion the bus shows the inverse, so a result taken at the wrong moment is caught.
    assign sar_result = analog_ctl.convert_en ? held_r : ~held_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            held_r <= 10'h000;
            conv_d_r <= 1'b0;
            strobes <= 5'h00;
        end else begin
            conv_d_r <= analog_ctl.convert_en;
            if (analog_ctl.sample_en) begin
                held_r <= code;
            end
            if (analog_ctl.convert_en && !conv_d_r) begin
                strobes <= {4'h0, analog_ctl.bit_strobe};
            end else if (analog_ctl.bit_strobe) begin
                strobes <= strobes + 5'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int RCD = 2;
    logic clk, rstn, wr, rd, trigger, flag, rd_seen;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    logic [9:0] code, sar_result, last;
    logic [4:0] strobes;
    logic [31:0] seed;
    logic [7:0] exp_q[$];
    adc_seq_pkg::analog_ctl_type actl;
    int mismatches, compares, cyc;

    adc_acquisition_sequencer #(.RC_DIV(RCD)) adc_acquisition_sequencer_inst (.clk(clk), .rstn(rstn),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .trigger(trigger),
        .sar_result(sar_result), .analog_ctl(actl), .conv_done_irq_flag(flag));
    sar_front_model sar_front_model_inst (.analog_ctl(actl), .clk(clk), .rstn(rstn), .code(code),
        .sar_result(sar_result), .strobes(strobes));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // The expectation is queued here and compared by the watcher when the data appear.
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask

    always @(posedge clk) begin
        if (rd_seen) check(rdata, exp_q.pop_front());
        rd_seen <= rd;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic run(input logic [2:0] ccs, input logic [2:0] acq, input logic trig);
        int tad, len, gap, pre, cv, rec, n;
        tad = (ccs[1:0] == 2'h3) ? RCD : (2 << (ccs[2] + 2 * ccs[1:0]));
        len = (acq == 3'h0) ? 0 : ((acq < 3'h5) ? 2 * acq : 4 * acq - 8);
        gap = 0;
        pre = 0;
        cv = 0;
        rec = 0;
        seed = lfsr(seed);
        code <= seed[9:0];
        wr_reg(adc_seq_pkg::CFG_IDX, {2'h0, acq, ccs});
        wr_reg(adc_seq_pkg::FLAG_IDX, 8'h00);
        wr_reg(adc_seq_pkg::CTRL_IDX, 8'h01);
        if (acq == 3'h0) repeat (8) @(posedge clk);
        if (trig) begin
            @(posedge clk);
            trigger <= 1'b1;
            @(posedge clk);
            trigger <= 1'b0;
        end else begin
            wr_reg(adc_seq_pkg::CTRL_IDX, 8'h03);
        end
        for (n = 0; n < 5000; n++) begin
            #1;
            if (actl.convert_en) cv++;
            else if (cv > 0) break;
            else if (actl.sample_en) pre++;
            else gap++;
            @(posedge clk);
        end
        for (n = 0; n < 5000 && !actl.sample_en; n++) begin
            rec++;
            @(posedge clk);
            #1;
        end
        check(cv, 11 * tad);
        check(strobes, 11);
        check(gap, (acq == 3'h0) ? 4 : 0);
        check(pre >= len * tad && pre <= len * tad + tad + 2, 1);
        check(rec >= 2 * tad - 1 && rec <= 2 * tad + 2, 1);
        rd_reg(adc_seq_pkg::FLAG_IDX, 8'h01);
        rd_reg(adc_seq_pkg::CTRL_IDX, 8'h01);
        rd_reg(adc_seq_pkg::RES_HI_IDX, {6'h00, code[9:8]});
        rd_reg(adc_seq_pkg::RES_LO_IDX, code[7:0]);
        last = code;
        $display("test conversion clk=%0d acq=%0d trig=%0d done", ccs, acq, trig);
    endtask

    initial begin
        rstn = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        trigger = 1'b0;
        code = 10'h000;
        last = 10'h000;
        rd_seen = 1'b0;
        seed = 32'h876F1833;
        mismatches = 0;
        compares = 0;
        cyc = 0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(adc_seq_pkg::CFG_IDX, 8'h00);
        rd_reg(adc_seq_pkg::FLAG_IDX, 8'h00);
        rd_reg(4'h9, 8'h00);
        @(posedge clk);
        trigger <= 1'b1;
        @(posedge clk);
        trigger <= 1'b0;
        rd_reg(adc_seq_pkg::CTRL_IDX, 8'h00);
        $display("test reset and idle trigger done");
        for (int i = 0; i < 8; i++) run(i[2:0], 3'h0, 1'b0);
        for (int i = 1; i < 8; i++) run(3'h0, i[2:0], 1'b0);
        // The clock runs on through every conversion, as in idle; this RC run stands for a sleep conversion.
        run(3'h7, 3'h2, 1'b1);
        wr_reg(adc_seq_pkg::FLAG_IDX, 8'h00);
        wr_reg(adc_seq_pkg::CFG_IDX, {2'h0, 3'h7, 3'h2});
        seed = lfsr(seed);
        code <= seed[9:0];
        wr_reg(adc_seq_pkg::CTRL_IDX, 8'h03);
        rd_reg(adc_seq_pkg::CTRL_IDX, 8'h03);
        for (int n = 0; n < 3000 && !actl.convert_en; n++) begin
            @(posedge clk);
            #1;
        end
        wr_reg(adc_seq_pkg::CTRL_IDX, 8'h01);
        repeat (200) @(posedge clk);
        rd_reg(adc_seq_pkg::RES_HI_IDX, {6'h00, last[9:8]});
        rd_reg(adc_seq_pkg::RES_LO_IDX, last[7:0]);
        rd_reg(adc_seq_pkg::FLAG_IDX, 8'h00);
        $display("test abort done");
        repeat (3) @(posedge clk);
        summarize();
    end
endmodule
`default_nettype wire
